// ===== core/msdma_regs.svh
// Function
// RULE_01: Two independent controllers exist, each with eight streams and its own memory port and peripheral port.
// RULE_02: Each stream moves data memory to memory, peripheral to memory or memory to peripheral, as configured.
// RULE_03: Each stream passes its data through a buffer between the two ports and may hold the bus for a burst of beats.
// RULE_04: In circular mode a stream that finishes its block reloads its start addresses and count and carries on alone.
// RULE_05: In double-buffer mode a stream swaps between two memory buffer addresses at the end of each block.
// RULE_06: A stream moves data when its own hardware request line is raised by the peripheral that it serves.
// RULE_07: A stream may be started by a software trigger instead, with no hardware request at all.
// RULE_08: Source and destination widths are set apart per stream and the data is packed or unpacked between them; the code drops leftover bytes at burst end.
// RULE_09: A stream raises its transfer-complete flag when its count reaches zero, and so at each buffer swap too.
`ifndef MSDMA_REGS_SVH
`define MSDMA_REGS_SVH
`define MSDMA_NSTREAM    8
`define MSDMA_SEL_W      3
`define MSDMA_NCTRL      2
`define MSDMA_BUF_DEPTH  2'h2
`define MSDMA_WORD_BYTES 3'h4
`define MSDMA_BYTE_SHIFT 3
`define MSDMA_CNT_ZERO   16'h0000
`define MSDMA_CNT_ONE    16'h0001
`define MSDMA_BEATS_1    5'h01
`define MSDMA_BEATS_4    5'h04
`define MSDMA_BEATS_8    5'h08
`define MSDMA_BEATS_16   5'h10
`define MSDMA_BEAT_LAST  5'h01
`endif

// ===== core/msdma_pkg.sv
`default_nettype none
`include "msdma_regs.svh"
package msdma_pkg;
    typedef enum logic [1:0] {MSDMA_P2M, MSDMA_M2P, MSDMA_M2M} msdma_dir_t;
    typedef enum logic [1:0] {MSDMA_IDLE, MSDMA_READ, MSDMA_RWAIT,
                              MSDMA_DRAIN} msdma_eng_t;

    typedef struct packed {
        logic        enable;
        msdma_dir_t  dir;
        logic        circ;
        logic        dbuf;
        logic        swTrig;
        logic        perInc;
        logic        memInc;
        logic [1:0]  srcSize;
        logic [1:0]  dstSize;
        logic [1:0]  burst;
        logic [15:0] count;
        logic [31:0] perAddr;
        logic [31:0] mem0Addr;
        logic [31:0] mem1Addr;
    } msdma_cfg_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } msdma_req_t;

    typedef struct packed {
        msdma_eng_t                       fsm;
        logic [`MSDMA_SEL_W-1:0]          cur;
        logic [4:0]                       beats;
        logic [31:0]                      acc;
        logic [2:0]                       fill;
        logic [1:0][31:0]                 fifo;
        logic                             wrPtr;
        logic                             rdPtr;
        logic [1:0]                       level;
        msdma_req_t                       perReq;
        msdma_req_t                       memReq;
        logic [`MSDMA_NSTREAM-1:0]        run;
        logic [`MSDMA_NSTREAM-1:0]        prevEn;
        logic [`MSDMA_NSTREAM-1:0]        tgt;
        logic [`MSDMA_NSTREAM-1:0]        tcFlag;
        logic [`MSDMA_NSTREAM-1:0][15:0]  cnt;
        logic [`MSDMA_NSTREAM-1:0][31:0]  pAddr;
        logic [`MSDMA_NSTREAM-1:0][31:0]  mAddr;
    } msdma_state_t;
endpackage : msdma_pkg
`default_nettype wire

// ===== core/msdma_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "msdma_regs.svh"

module msdma_ctrl import msdma_pkg::*; (
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    input  wire msdma_cfg_t [`MSDMA_NSTREAM-1:0] cfg,
    input  wire logic [`MSDMA_NSTREAM-1:0]  hwReq,
    input  wire logic [`MSDMA_NSTREAM-1:0]  tcClear,
    output var  msdma_req_t                 perReq,
    input  wire logic                       perReady,
    input  wire logic                       perRvalid,
    input  wire logic [31:0]                perRdata,
    output var  msdma_req_t                 memReq,
    input  wire logic                       memReady,
    input  wire logic                       memRvalid,
    input  wire logic [31:0]                memRdata,
    output var  logic [`MSDMA_NSTREAM-1:0]  tcFlag,
    output var  logic [`MSDMA_NSTREAM-1:0]  curTarget
);
    msdma_state_t r;
    msdma_state_t next_r;

    function automatic logic [2:0] bytesOf(input logic [1:0] sz);
        bytesOf = 3'h1 << sz;
    endfunction : bytesOf

    function automatic logic [4:0] beatsOf(input logic [1:0] b);
        unique case (b)
            2'h0:    beatsOf = `MSDMA_BEATS_1;
            2'h1:    beatsOf = `MSDMA_BEATS_4;
            2'h2:    beatsOf = `MSDMA_BEATS_8;
            default: beatsOf = `MSDMA_BEATS_16;
        endcase
    endfunction : beatsOf

    logic                  srcIsMem;
    logic [2:0]            srcB;
    logic [2:0]            dstB;
    msdma_req_t            srcQ;
    msdma_req_t            dstQ;
    logic                  srcRdy;
    logic                  dstRdy;
    logic                  srcRv;
    logic [31:0]           srcRd;
    logic [31:0]           srcMask;
    logic                  found;
    logic [`MSDMA_SEL_W-1:0] pick;
    logic                  endBlock;
    logic [`MSDMA_SEL_W-1:0] c;

    always_comb begin
        next_r   = r;
        c        = r.cur;
        srcIsMem = (cfg[c].dir == MSDMA_M2P);
        srcB     = bytesOf(cfg[c].srcSize);
        dstB     = bytesOf(cfg[c].dstSize);
        srcQ     = srcIsMem ? r.memReq : r.perReq;
        dstQ     = srcIsMem ? r.perReq : r.memReq;
        srcRdy   = srcIsMem ? memReady : perReady;
        dstRdy   = srcIsMem ? perReady : memReady;
        srcRv    = srcIsMem ? memRvalid : perRvalid;
        srcRd    = srcIsMem ? memRdata : perRdata;
        srcMask  = 32'hFFFFFFFF >> (6'(`MSDMA_WORD_BYTES - srcB)
                                    << `MSDMA_BYTE_SHIFT);
        found    = 1'b0;
        pick     = '0;
        endBlock = 1'b0;
        for (int i = `MSDMA_NSTREAM - 1; i >= 0; i--) begin
            next_r.prevEn[i] = cfg[i].enable;
            if (tcClear[i])
                next_r.tcFlag[i] = 1'b0;
            if (cfg[i].enable && !r.prevEn[i]) begin
                next_r.run[i]   = 1'b1;
                next_r.tgt[i]   = 1'b0;
                next_r.cnt[i]   = cfg[i].count;
                next_r.pAddr[i] = cfg[i].perAddr;
                next_r.mAddr[i] = cfg[i].mem0Addr;
            end else if (!cfg[i].enable) begin
                next_r.run[i] = 1'b0;
            end
            // RULE_06 hardware request gate
            // RULE_07 software trigger start
            if (r.run[i] && r.cnt[i] != `MSDMA_CNT_ZERO &&
                (cfg[i].swTrig || cfg[i].dir == MSDMA_M2M || hwReq[i])) begin
                found = 1'b1;
                pick  = `MSDMA_SEL_W'(i);
            end
        end
        // RULE_03 write side drains buffer
        if (dstQ.valid && dstRdy) begin
            dstQ.valid     = 1'b0;
            next_r.level   = next_r.level - 2'h1;
            next_r.rdPtr   = ~r.rdPtr;
            if (srcIsMem && cfg[c].perInc)
                next_r.pAddr[c] = r.pAddr[c] + 32'(dstB);
            if (!srcIsMem && cfg[c].memInc)
                next_r.mAddr[c] = r.mAddr[c] + 32'(dstB);
        end
        // RULE_08 unpack to destination width
        if (r.fill >= dstB && r.level < `MSDMA_BUF_DEPTH) begin
            next_r.fifo[r.wrPtr] = r.acc;
            next_r.acc   = r.acc >> (6'(dstB) << `MSDMA_BYTE_SHIFT);
            next_r.fill  = r.fill - dstB;
            next_r.level = next_r.level + 2'h1;
            next_r.wrPtr = ~r.wrPtr;
        end
        if (srcQ.valid && srcRdy)
            srcQ.valid = 1'b0;
        unique case (r.fsm)
            MSDMA_IDLE: begin
                if (found) begin
                    next_r.cur   = pick;
                    // RULE_03 burst length per grant
                    next_r.beats = beatsOf(cfg[pick].burst);
                    next_r.fsm   = MSDMA_READ;
                end
            end
            MSDMA_READ: begin
                if (4'(next_r.fill) + 4'(srcB) <= 4'(`MSDMA_WORD_BYTES)) begin
                    srcQ.valid = 1'b1;
                    srcQ.write = 1'b0;
                    srcQ.size  = cfg[c].srcSize;
                    srcQ.addr  = srcIsMem ? r.mAddr[c] : r.pAddr[c];
                    srcQ.wdata = '0;
                    next_r.fsm = MSDMA_RWAIT;
                end
            end
            MSDMA_RWAIT: begin
                if (srcRv && !r.memReq.valid && !r.perReq.valid ||
                    srcRv && !(srcIsMem ? r.memReq.valid : r.perReq.valid))
                begin
                    // RULE_08 pack source items
                    next_r.acc  = next_r.acc | ((srcRd & srcMask)
                                  << (6'(next_r.fill) << `MSDMA_BYTE_SHIFT));
                    next_r.fill = next_r.fill + srcB;
                    next_r.cnt[c] = r.cnt[c] - `MSDMA_CNT_ONE;
                    next_r.beats  = r.beats - `MSDMA_BEAT_LAST;
                    if (srcIsMem && cfg[c].memInc)
                        next_r.mAddr[c] = next_r.mAddr[c] + 32'(srcB);
                    if (!srcIsMem && cfg[c].perInc)
                        next_r.pAddr[c] = next_r.pAddr[c] + 32'(srcB);
                    next_r.fsm = (r.cnt[c] == `MSDMA_CNT_ONE ||
                                  r.beats == `MSDMA_BEAT_LAST) ?
                                 MSDMA_DRAIN : MSDMA_READ;
                end
            end
            MSDMA_DRAIN: begin
                if (next_r.fill < dstB && next_r.level == 2'h0 &&
                    !dstQ.valid) begin
                    // Odd leftover bytes are dropped at the end of each burst
                    next_r.fill = '0;
                    next_r.acc  = '0;
                    next_r.fsm  = MSDMA_IDLE;
                    endBlock    = (r.cnt[c] == `MSDMA_CNT_ZERO);
                end
            end
            default: next_r.fsm = MSDMA_IDLE;
        endcase
        if (endBlock) begin
            // RULE_09 flag on count zero
            next_r.tcFlag[c] = 1'b1;
            if (cfg[c].dbuf || cfg[c].circ) begin
                // RULE_04 reload on wrap
                next_r.cnt[c]   = cfg[c].count;
                next_r.pAddr[c] = cfg[c].perAddr;
                next_r.mAddr[c] = cfg[c].mem0Addr;
                // RULE_05 swap memory buffer
                if (cfg[c].dbuf) begin
                    next_r.tgt[c] = ~r.tgt[c];
                    if (!r.tgt[c])
                        next_r.mAddr[c] = cfg[c].mem1Addr;
                end
            end else begin
                next_r.run[c] = 1'b0;
            end
        end
        if (!dstQ.valid && next_r.level != 2'h0) begin
            dstQ.valid = 1'b1;
            dstQ.write = 1'b1;
            dstQ.size  = cfg[c].dstSize;
            dstQ.addr  = srcIsMem ? next_r.pAddr[c] : next_r.mAddr[c];
            dstQ.wdata = next_r.fifo[next_r.rdPtr];
        end
        // RULE_02 route by direction
        next_r.memReq = srcIsMem ? srcQ : dstQ;
        next_r.perReq = srcIsMem ? dstQ : srcQ;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign perReq    = r.perReq;
    assign memReq    = r.memReq;
    assign tcFlag    = r.tcFlag;
    assign curTarget = r.tgt;

    property p_dir_route;
        @(posedge ref_clk) disable iff (reset)
        r.memReq.valid && !r.memReq.write |-> cfg[r.cur].dir == MSDMA_M2P;
    endproperty
    a_dir_route: assert property (p_dir_route) // RULE_02
        else $error("memory port read outside memory-to-peripheral");

    property p_buf_bound;
        @(posedge ref_clk) disable iff (reset)
        r.level <= `MSDMA_BUF_DEPTH && r.fill <= `MSDMA_WORD_BYTES;
    endproperty
    a_buf_bound: assert property (p_buf_bound) // RULE_03
        else $error("buffer or packer overfilled");

    property p_req_hold;
        @(posedge ref_clk) disable iff (reset)
        r.memReq.valid && !memReady |=>
            r.memReq.valid && $stable(r.memReq.addr);
    endproperty
    a_req_hold: assert property (p_req_hold) // RULE_03
        else $error("memory request dropped before acceptance");

    property p_circ_reload;
        @(posedge ref_clk) disable iff (reset)
        endBlock && cfg[c].circ && !cfg[c].dbuf |=>
            r.cnt[$past(c)] == cfg[$past(c)].count && r.run[$past(c)];
    endproperty
    a_circ_reload: assert property (p_circ_reload) // RULE_04
        else $error("circular stream did not reload");

    property p_dbuf_swap;
        @(posedge ref_clk) disable iff (reset)
        endBlock && cfg[c].dbuf |=> r.tgt[$past(c)] != $past(r.tgt[c]);
    endproperty
    a_dbuf_swap: assert property (p_dbuf_swap) // RULE_05
        else $error("double buffer target did not swap");

    property p_hw_gate;
        @(posedge ref_clk) disable iff (reset)
        r.fsm == MSDMA_IDLE && next_r.fsm == MSDMA_READ &&
        cfg[pick].dir != MSDMA_M2M && !cfg[pick].swTrig |-> hwReq[pick];
    endproperty
    a_hw_gate: assert property (p_hw_gate) // RULE_06
        else $error("stream started without its request");

    property p_sw_go;
        @(posedge ref_clk) disable iff (reset)
        r.fsm == MSDMA_IDLE && r.run[0] && cfg[0].swTrig &&
        r.cnt[0] != `MSDMA_CNT_ZERO |=> r.fsm == MSDMA_READ && r.cur == '0;
    endproperty
    a_sw_go: assert property (p_sw_go) // RULE_07
        else $error("software trigger did not start stream");

    property p_width_pack;
        @(posedge ref_clk) disable iff (reset)
        r.fsm == MSDMA_RWAIT && next_r.fsm != MSDMA_RWAIT |->
            next_r.fill >= srcB;
    endproperty
    a_width_pack: assert property (p_width_pack) // RULE_08
        else $error("packer lost source bytes");

    property p_tc_flag;
        @(posedge ref_clk) disable iff (reset)
        endBlock |=> r.tcFlag[$past(c)] ##1 r.fsm != MSDMA_DRAIN;
    endproperty
    a_tc_flag: assert property (p_tc_flag) // RULE_09
        else $error("transfer complete flag not set");
endmodule : msdma_ctrl

module msdma_top import msdma_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire msdma_cfg_t [`MSDMA_NCTRL-1:0][`MSDMA_NSTREAM-1:0] cfg,
    input  wire logic [`MSDMA_NCTRL-1:0][`MSDMA_NSTREAM-1:0] hwReq,
    input  wire logic [`MSDMA_NCTRL-1:0][`MSDMA_NSTREAM-1:0] tcClear,
    output var  msdma_req_t [`MSDMA_NCTRL-1:0] perReq,
    input  wire logic [`MSDMA_NCTRL-1:0]     perReady,
    input  wire logic [`MSDMA_NCTRL-1:0]     perRvalid,
    input  wire logic [`MSDMA_NCTRL-1:0][31:0] perRdata,
    output var  msdma_req_t [`MSDMA_NCTRL-1:0] memReq,
    input  wire logic [`MSDMA_NCTRL-1:0]     memReady,
    input  wire logic [`MSDMA_NCTRL-1:0]     memRvalid,
    input  wire logic [`MSDMA_NCTRL-1:0][31:0] memRdata,
    output var  logic [`MSDMA_NCTRL-1:0][`MSDMA_NSTREAM-1:0] tcFlag,
    output var  logic [`MSDMA_NCTRL-1:0][`MSDMA_NSTREAM-1:0] curTarget
);
    // RULE_01 first and second transfer controller
    for (genvar k = 0; k < `MSDMA_NCTRL; k++) begin : g_ctrl
        msdma_ctrl u_ctrl (
            .ref_clk   (ref_clk),
            .reset     (reset),
            .cfg       (cfg[k]),
            .hwReq     (hwReq[k]),
            .tcClear   (tcClear[k]),
            .perReq    (perReq[k]),
            .perReady  (perReady[k]),
            .perRvalid (perRvalid[k]),
            .perRdata  (perRdata[k]),
            .memReq    (memReq[k]),
            .memReady  (memReady[k]),
            .memRvalid (memRvalid[k]),
            .memRdata  (memRdata[k]),
            .tcFlag    (tcFlag[k]),
            .curTarget (curTarget[k])
        );
    end
endmodule : msdma_top
`default_nettype wire

// ===== test/msdma_port_model.sv
`timescale 1ns/100ps
`default_nettype none

module msdma_port_model import msdma_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire msdma_req_t  req,
    output var  logic        ready,
    output var  logic        rvalid,
    output var  logic [31:0] rdata
);
    logic [31:0] wAddr[$];
    logic [31:0] wData[$];
    logic [1:0]  wSize[$];
    logic [1:0]  pend;
    logic [31:0] pendData;
    logic        tick;

    // Narrow items replicated so any lane choice sees the same item
    function automatic logic [31:0] srcWord(input logic [31:0] a,
                                            input logic [1:0]  sz);
        logic [31:0] w;
        for (int i = 0; i < 4; i++)
            w[8*i +: 8] = 8'(a + i) ^ 8'h5A;
        srcWord = (sz == 2'h0) ? {4{w[7:0]}} :
                  (sz == 2'h1) ? {2{w[15:0]}} : w;
    endfunction : srcWord

    always @(posedge ref_clk) begin
        if (reset) begin
            wAddr.delete();
            wData.delete();
            wSize.delete();
            ready <= 1'b0;
            rvalid <= 1'b0;
            pend <= 2'h0;
            tick <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            tick <= ~tick;
            ready <= slow ? tick : 1'b1;
            rvalid <= 1'b0;
            // Stale data is inverted every cycle outside a valid beat
            rdata <= ~rdata;
            if (pend == 2'h1) begin
                rvalid <= 1'b1;
                rdata <= pendData;
            end
            if (pend != 2'h0)
                pend <= pend - 2'h1;
            if (req.valid && ready) begin
                if (req.write) begin
                    wAddr.push_back(req.addr);
                    wData.push_back(req.wdata);
                    wSize.push_back(req.size);
                end else begin
                    pendData <= srcWord(req.addr, req.size);
                    pend <= slow ? 2'h3 : 2'h1;
                end
            end
        end
    end
endmodule : msdma_port_model

`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        nCompared++; \
        if ((got) !== (ex)) begin \
            errCount++; \
            $display("unexpected %s: expected %0h seen %0h", nm, ex, got); \
        end \
    end

module tb_top import msdma_pkg::*;;
    logic                  ref_clk = 1'b0;
    logic                  reset;
    msdma_cfg_t [1:0][7:0] cfg;
    logic [1:0][7:0]       hwReq;
    logic [1:0][7:0]       tcClear;
    msdma_req_t [1:0]      perReq;
    msdma_req_t [1:0]      memReq;
    logic [1:0]            perReady;
    logic [1:0]            perRvalid;
    logic [1:0]            memReady;
    logic [1:0]            memRvalid;
    logic [1:0][31:0]      perRdata;
    logic [1:0][31:0]      memRdata;
    logic [1:0][7:0]       tcFlag;
    logic [1:0][7:0]       curTarget;
    logic [3:0]            slow;
    int                    errCount = 0;
    int                    nCompared = 0;
    int                    cyc = 0;

    always #2.5 ref_clk = ~ref_clk;

    msdma_top dut (.ref_clk(ref_clk), .reset(reset), .cfg(cfg),
        .hwReq(hwReq), .tcClear(tcClear), .perReq(perReq),
        .perReady(perReady), .perRvalid(perRvalid), .perRdata(perRdata),
        .memReq(memReq), .memReady(memReady), .memRvalid(memRvalid),
        .memRdata(memRdata), .tcFlag(tcFlag), .curTarget(curTarget));
    msdma_port_model per0 (.ref_clk(ref_clk), .reset(reset), .slow(slow[0]),
        .req(perReq[0]), .ready(perReady[0]), .rvalid(perRvalid[0]),
        .rdata(perRdata[0]));
    msdma_port_model mem0 (.ref_clk(ref_clk), .reset(reset), .slow(slow[1]),
        .req(memReq[0]), .ready(memReady[0]), .rvalid(memRvalid[0]),
        .rdata(memRdata[0]));
    msdma_port_model per1 (.ref_clk(ref_clk), .reset(reset), .slow(slow[2]),
        .req(perReq[1]), .ready(perReady[1]), .rvalid(perRvalid[1]),
        .rdata(perRdata[1]));
    msdma_port_model mem1 (.ref_clk(ref_clk), .reset(reset), .slow(slow[3]),
        .req(memReq[1]), .ready(memReady[1]), .rvalid(memRvalid[1]),
        .rdata(memRdata[1]));

    function automatic logic [31:0] word(input logic [31:0] a);
        for (int i = 0; i < 4; i++)
            word[8*i +: 8] = 8'(a + i) ^ 8'h5A;
    endfunction : word

    function automatic msdma_cfg_t mk(input msdma_dir_t d,
        input logic [1:0] ss, input logic [1:0] ds, input logic [15:0] n,
        input logic [31:0] pa, input logic [31:0] ma);
        mk = '0;
        mk.enable = 1'b1;
        mk.dir = d;
        mk.swTrig = 1'b1;
        mk.perInc = 1'b1;
        mk.memInc = 1'b1;
        mk.srcSize = ss;
        mk.dstSize = ds;
        mk.count = n;
        mk.perAddr = pa;
        mk.mem0Addr = ma;
    endfunction : mk

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic restart(input int n);
        reset = 1'b1;
        cfg = '0;
        hwReq = '0;
        tcClear = '0;
        slow = 4'h0;
        step(n);
        reset = 1'b0;
        step(1);
    endtask : restart

    task automatic completeRun;
        $display("Compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : completeRun

    task automatic burstOrder;
        restart(2);
        slow[1] = 1'b1;
        cfg[0][1] = mk(MSDMA_M2M, 2'h2, 2'h2, 16'h0001, 32'h0300, 32'h0300);
        cfg[0][0] = mk(MSDMA_M2M, 2'h2, 2'h2, 16'h0008, 32'h0100, 32'h0400);
        cfg[0][0].burst = 2'h1;
        for (int i = 0; i < 1000 && tcFlag[0][1:0] !== 2'h3; i++)
            step(1);
        for (int i = 0; i < 8; i++) begin
            `CHK("burstAddr", 32'h0400 + 4 * i, mem0.wAddr[i])
            `CHK("burstData", word(32'h0100 + 4 * i), mem0.wData[i])
        end
        `CHK("lateAddr", 32'h0000_0300, mem0.wAddr[8])
        `CHK("tcBoth", 2'h3, tcFlag[0][1:0])
        tcClear[0] = 8'h03;
        step(1);
        tcClear[0] = 8'h00;
        step(1);
        `CHK("tcCleared", 2'h0, tcFlag[0][1:0])
    endtask : burstOrder

    task automatic hwPack;
        restart(2);
        cfg[1][3] = mk(MSDMA_P2M, 2'h0, 2'h2, 16'h0004, 32'h0040, 32'h0800);
        cfg[1][3].swTrig = 1'b0;
        // One grant must gather the whole word, else leftover bytes drop
        cfg[1][3].burst = 2'h3;
        step(30);
        `CHK("idleWrites", 0, mem1.wAddr.size())
        hwReq[1][3] = 1'b1;
        for (int i = 0; i < 1000 && tcFlag[1][3] !== 1'b1; i++)
            step(1);
        hwReq[1][3] = 1'b0;
        `CHK("packCount", 1, mem1.wAddr.size())
        `CHK("packAddr", 32'h0000_0800, mem1.wAddr[0])
        `CHK("packData", word(32'h0040), mem1.wData[0])
        `CHK("packSize", 2'h2, mem1.wSize[0])
    endtask : hwPack

    task automatic splitWrites;
        logic [31:0] w;
        w = word(32'h0600);
        restart(2);
        slow[0] = 1'b1;
        cfg[0][2] = mk(MSDMA_M2P, 2'h2, 2'h1, 16'h0001, 32'h0080, 32'h0600);
        for (int i = 0; i < 1000 && tcFlag[0][2] !== 1'b1; i++)
            step(1);
        `CHK("splitAddr0", 32'h0000_0080, per0.wAddr[0])
        `CHK("splitAddr1", 32'h0000_0082, per0.wAddr[1])
        `CHK("splitSize", 2'h1, per0.wSize[1])
        `CHK("splitLow", w[15:0], per0.wData[0][15:0])
        `CHK("splitHigh", w[31:16], per0.wData[1][15:0])
    endtask : splitWrites

    task automatic circular;
        restart(2);
        cfg[0][5] = mk(MSDMA_M2M, 2'h2, 2'h2, 16'h0002, 32'h0020, 32'h0A00);
        cfg[0][5].circ = 1'b1;
        cfg[0][5].burst = 2'h2;
        for (int i = 0; i < 1000 && mem0.wAddr.size() < 4; i++)
            step(1);
        cfg[0][5].enable = 1'b0;
        for (int i = 0; i < 4; i++) begin
            `CHK("circAddr", 32'h0A00 + 4 * (i % 2), mem0.wAddr[i])
            `CHK("circData", word(32'h0020 + 4 * (i % 2)), mem0.wData[i])
        end
    endtask : circular

    task automatic doubleBuf;
        restart(2);
        cfg[0][6] = mk(MSDMA_M2M, 2'h2, 2'h2, 16'h0001, 32'h0010, 32'h0C00);
        cfg[0][6].dbuf = 1'b1;
        cfg[0][6].mem1Addr = 32'h0000_0E00;
        for (int i = 0; i < 1000 && mem0.wAddr.size() < 3; i++)
            step(1);
        cfg[0][6].enable = 1'b0;
        for (int i = 0; i < 3; i++)
            `CHK("dbufAddr", (i % 2) ? 32'h0E00 : 32'h0C00, mem0.wAddr[i])
        `CHK("dbufFlag", 1'b1, tcFlag[0][6])
        `CHK("dbufTarget", 1'b1, curTarget[0][6])
    endtask : doubleBuf

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errCount++;
            completeRun();
        end
    end

    initial begin
        restart(16);
        burstOrder();
        hwPack();
        splitWrites();
        circular();
        doubleBuf();
        completeRun();
    end
endmodule : tb_top

`default_nettype wire
